// file: design/hcf_calib_feedback.v
/*
 * Haptic calibration and feedback register bank with its two-wire bus slave,
 * the calibration sequencer and the drive and feedback gain scaling.
 * Assumes serial clock and data arrive asynchronously from pins and that the
 * calibration measurements and playback controls come from logic on sys_clk.
 */
// Notes on behaviour
// R1: In closed loop, overdrive drive level is capped at the overdrive clamp value.
// R2: In closed loop, overdrive and braking may exceed the rated voltage level.
// R3: In open loop, the clamp value is the full-scale reference; resets to 0x89.
// R4: Calibration end stores loss compensation at 0x18; reset 0x0D.
// R5: Compensation coefficient equals one plus register value over 255.
// R6: Playback drive gain is multiplied by the compensation coefficient.
// R7: Calibration measures actuator impedance and derives the compensation value.
// R8: Compensation value offsets resistive losses in the output path.
// R9: Calibration end stores rated back-EMF at 0x19; reset 0x6D.
// R10: Back-EMF scales as value over 255 times 1.22 V over back-EMF gain.
// R11: Stored back-EMF selects the closed-loop feedback gain automatically.
// R12: Feedback control: type bit 7, brake 6-4, loop 3-2, back-EMF gain 1-0.
// R13: Type bit 0 selects ERM, 1 selects LRA; set before calibration.
// R14: Brake ratio codes 0 to 6 mean 1x,2x,3x,4x,6x,8x,16x.
// R15: Host programs rated voltage before calibration, which reads it.
// R16: Host reruns calibration after changing the rated voltage.
// R17: Host-written result values stand until the next calibration overwrites them.
`timescale 1ns/1ps
`include "hcf_regs.vh"
`default_nettype none

module hcf_calib_feedback (
	// Clock and reset.
	input wire sys_clk,
	input wire rst_n,
	// Two-wire bus pins.
	input wire sclIn,
	input wire sdaIn,
	output reg sdaOut,
	output reg sdaOe,
	// Calibration control and measurements.
	input wire calStart,
	input wire measValid,
	input wire [7:0] measImpedance,
	input wire [7:0] measBackemf,
	output reg calBusy,
	output reg calDone,
	output reg [7:0] calRatedRef,
	// Playback controls.
	input wire loopClosed,
	input wire overdriveActive,
	input wire brakeActive,
	input wire [7:0] playAmp,
	// Drive and feedback outputs.
	output reg [7:0] driveRef,
	output reg [7:0] driveLevel,
	output reg [11:0] feedbackGain,
	output reg actuatorLra
);

////////////////////////////////////////////////////////////////////////////////
// Decoding functions.

	function [4:0] brakeMult;
		input [2:0] code;
		begin
			case (code) // R14
				3'h0: brakeMult = 5'h01;
				3'h1: brakeMult = 5'h02;
				3'h2: brakeMult = 5'h03;
				3'h3: brakeMult = 5'h04;
				3'h4: brakeMult = 5'h06;
				3'h5: brakeMult = 5'h08;
				default: brakeMult = 5'h10;
			endcase
		end
	endfunction

	function isMapped;
		input [7:0] ofs;
		begin
			isMapped = (ofs >= `HCF_OFS_RATED_VOLTAGE) && (ofs <= `HCF_OFS_FEEDBACK_CTRL);
		end
	endfunction

////////////////////////////////////////////////////////////////////////////////
// Pin synchronisers and bus edge detection.

	reg [1:0] sclSync_reg;
	reg [1:0] sdaSync_reg;
	reg sclPrev_reg;
	reg sdaPrev_reg;
	wire sclRise = sclSync_reg[1] & ~sclPrev_reg;
	wire sclFall = ~sclSync_reg[1] & sclPrev_reg;
	wire busStart = sclSync_reg[1] & sclPrev_reg & sdaPrev_reg & ~sdaSync_reg[1];
	wire busStop = sclSync_reg[1] & sclPrev_reg & ~sdaPrev_reg & sdaSync_reg[1];

	always @(posedge sys_clk) begin
		if (!rst_n) begin
			sclSync_reg <= 2'h3;
			sdaSync_reg <= 2'h3;
			sclPrev_reg <= 1'b1;
			sdaPrev_reg <= 1'b1;
		end else begin
			sclSync_reg <= {sclSync_reg[0], sclIn};
			sdaSync_reg <= {sdaSync_reg[0], sdaIn};
			sclPrev_reg <= sclSync_reg[1];
			sdaPrev_reg <= sdaSync_reg[1];
		end
	end

////////////////////////////////////////////////////////////////////////////////
// Register bank.

	reg [7:0] ratedVoltage_reg;
	reg [7:0] overdriveLimitLevel_reg;
	reg [7:0] calibLossComp_reg;
	reg [7:0] calibBackemfLevel_reg;
	reg [7:0] feedbackCtrl_reg;
	reg [7:0] regPtr_reg;
	reg hostWrite;
	reg [7:0] hostData;
	reg calStore;
	reg [7:0] calCompValue;
	reg [7:0] calBemfValue;

	wire actuatorTypeSel = feedbackCtrl_reg[`HCF_FB_ACT_TYPE_BIT];
	wire [2:0] brakeGainRatio = feedbackCtrl_reg[`HCF_FB_BRAKE_MSB:`HCF_FB_BRAKE_LSB];
	wire [1:0] loopGainSel = feedbackCtrl_reg[`HCF_FB_LOOP_MSB:`HCF_FB_LOOP_LSB];
	wire [1:0] backemfAmpScale = feedbackCtrl_reg[`HCF_FB_BEMF_MSB:`HCF_FB_BEMF_LSB];

	reg [7:0] readData;
	always @* begin
		case (regPtr_reg)
			`HCF_OFS_RATED_VOLTAGE: readData = ratedVoltage_reg;
			`HCF_OFS_OVERDRIVE_CLAMP: readData = overdriveLimitLevel_reg;
			`HCF_OFS_CALIB_LOSS_COMP: readData = calibLossComp_reg;
			`HCF_OFS_CALIB_BACKEMF: readData = calibBackemfLevel_reg;
			`HCF_OFS_FEEDBACK_CTRL: readData = feedbackCtrl_reg;
			default: readData = 8'h00;
		endcase
	end

	always @(posedge sys_clk) begin
		if (!rst_n) begin
			ratedVoltage_reg <= `HCF_RST_RATED_VOLTAGE;
			overdriveLimitLevel_reg <= `HCF_RST_OVERDRIVE_CLAMP; // R3
			calibLossComp_reg <= `HCF_RST_CALIB_LOSS_COMP; // R4
			calibBackemfLevel_reg <= `HCF_RST_CALIB_BACKEMF; // R9
			feedbackCtrl_reg <= `HCF_RST_FEEDBACK_CTRL; // R12
		end else begin
			if (hostWrite) begin
				case (regPtr_reg)
					`HCF_OFS_RATED_VOLTAGE: ratedVoltage_reg <= hostData;
					`HCF_OFS_OVERDRIVE_CLAMP: overdriveLimitLevel_reg <= hostData;
					`HCF_OFS_CALIB_LOSS_COMP: calibLossComp_reg <= hostData; // R17
					`HCF_OFS_CALIB_BACKEMF: calibBackemfLevel_reg <= hostData; // R17
					`HCF_OFS_FEEDBACK_CTRL: feedbackCtrl_reg <= hostData; // R12
					default: ;
				endcase
			end
			if (calStore) begin
				calibLossComp_reg <= calCompValue; // R4
				calibBackemfLevel_reg <= calBemfValue; // R9
			end
		end
	end

////////////////////////////////////////////////////////////////////////////////
// Two-wire bus slave.

	localparam BS_IDLE = 3'h0;
	localparam BS_RX = 3'h1;
	localparam BS_ACK = 3'h2;
	localparam BS_TX = 3'h3;
	localparam BS_RACK = 3'h4;
	localparam BK_ADDR = 2'h0;
	localparam BK_PTR = 2'h1;
	localparam BK_DATA = 2'h2;

	reg [2:0] busState_reg;
	reg [1:0] byteKind_reg;
	reg [3:0] bitCnt_reg;
	reg [7:0] shift_reg;
	reg readMode_reg;
	reg masterAck_reg;

	always @(posedge sys_clk) begin
		if (!rst_n) begin
			busState_reg <= BS_IDLE;
			byteKind_reg <= BK_ADDR;
			bitCnt_reg <= 4'h0;
			shift_reg <= 8'h00;
			readMode_reg <= 1'b0;
			masterAck_reg <= 1'b0;
			regPtr_reg <= 8'h00;
			sdaOut <= 1'b0;
			sdaOe <= 1'b0;
			hostWrite <= 1'b0;
			hostData <= 8'h00;
		end else begin
			hostWrite <= 1'b0;
			if (busStop) begin
				busState_reg <= BS_IDLE;
				sdaOe <= 1'b0;
			end else if (busStart) begin
				busState_reg <= BS_RX;
				byteKind_reg <= BK_ADDR;
				bitCnt_reg <= 4'h0;
				sdaOe <= 1'b0;
			end else begin
				case (busState_reg)
					BS_IDLE: sdaOe <= 1'b0;
					BS_RX: begin
						if (sclRise && bitCnt_reg < 4'h8) begin
							shift_reg <= {shift_reg[6:0], sdaSync_reg[1]};
							bitCnt_reg <= bitCnt_reg + 4'h1;
						end else if (sclFall && bitCnt_reg == 4'h8) begin
							busState_reg <= BS_ACK;
							sdaOe <= 1'b1;
							case (byteKind_reg)
								BK_ADDR: begin
									if (shift_reg[7:1] == `HCF_DEV_ADDR) begin
										readMode_reg <= shift_reg[0];
									end else begin
										busState_reg <= BS_IDLE;
										sdaOe <= 1'b0;
									end
								end
								BK_PTR: regPtr_reg <= shift_reg;
								default: begin
									hostWrite <= isMapped(regPtr_reg);
									hostData <= shift_reg;
								end
							endcase
						end
					end
					BS_ACK: begin
						if (sclFall) begin
							bitCnt_reg <= 4'h0;
							if (byteKind_reg == BK_DATA) begin
								regPtr_reg <= regPtr_reg + 8'h01;
							end
							if (byteKind_reg == BK_ADDR && readMode_reg) begin
								busState_reg <= BS_TX;
								shift_reg <= {readData[6:0], 1'b0};
								sdaOe <= ~readData[7];
								bitCnt_reg <= 4'h1;
							end else begin
								busState_reg <= BS_RX;
								sdaOe <= 1'b0;
								byteKind_reg <= (byteKind_reg == BK_ADDR) ? BK_PTR : BK_DATA;
							end
						end
					end
					BS_TX: begin
						if (sclFall) begin
							if (bitCnt_reg == 4'h8) begin
								busState_reg <= BS_RACK;
								sdaOe <= 1'b0;
								regPtr_reg <= regPtr_reg + 8'h01;
							end else begin
								sdaOe <= ~shift_reg[7];
								shift_reg <= {shift_reg[6:0], 1'b0};
								bitCnt_reg <= bitCnt_reg + 4'h1;
							end
						end
					end
					BS_RACK: begin
						if (sclRise) begin
							masterAck_reg <= ~sdaSync_reg[1];
						end else if (sclFall) begin
							if (masterAck_reg) begin
								busState_reg <= BS_TX;
								shift_reg <= {readData[6:0], 1'b0};
								sdaOe <= ~readData[7];
								bitCnt_reg <= 4'h1;
							end else begin
								busState_reg <= BS_IDLE;
							end
						end
					end
					default: busState_reg <= BS_IDLE;
				endcase
			end
		end
	end

////////////////////////////////////////////////////////////////////////////////
// Calibration sequencer.

	localparam CS_IDLE = 2'h0;
	localparam CS_IMPEDANCE = 2'h1;
	localparam CS_BACKEMF = 2'h2;

	reg [1:0] calState_reg;

	always @(posedge sys_clk) begin
		if (!rst_n) begin
			calState_reg <= CS_IDLE;
			calBusy <= 1'b0;
			calDone <= 1'b0;
			calRatedRef <= 8'h00;
			calStore <= 1'b0;
			calCompValue <= 8'h00;
			calBemfValue <= 8'h00;
		end else begin
			calDone <= 1'b0;
			calStore <= 1'b0;
			case (calState_reg)
				CS_IDLE: begin
					if (calStart) begin
						calState_reg <= CS_IMPEDANCE;
						calBusy <= 1'b1;
						calRatedRef <= ratedVoltage_reg; // R15
					end
				end
				CS_IMPEDANCE: begin
					if (measValid) begin
						// Lower impedance loses more in the driver, so it needs more boost.
						calCompValue <= 8'hFF - measImpedance; // R7 R8
						calState_reg <= CS_BACKEMF;
					end
				end
				CS_BACKEMF: begin
					if (measValid) begin
						calBemfValue <= measBackemf; // R9
						calStore <= 1'b1; // R4
						calDone <= 1'b1;
						calBusy <= 1'b0;
						calState_reg <= CS_IDLE;
					end
				end
				default: calState_reg <= CS_IDLE;
			endcase
		end
	end

////////////////////////////////////////////////////////////////////////////////
// Drive reference, compensated drive level and feedback gain.

	// Full amplitude times twice full scale needs seventeen bits.
	wire [16:0] ampProduct = {9'h000, playAmp} *
		({9'h000, calibLossComp_reg} + {1'b0, `HCF_CODE_FULL_SCALE});
	wire [16:0] ampScaled = ampProduct / {1'b0, `HCF_CODE_FULL_SCALE}; // R5 R6
	wire [7:0] ampSat = (ampScaled[16:8] != 9'h000) ? 8'hFF : ampScaled[7:0];
	wire raiseAllowed = loopClosed & (overdriveActive | brakeActive); // R2
	wire [7:0] refNext = !loopClosed ? overdriveLimitLevel_reg : // R3
		raiseAllowed ? overdriveLimitLevel_reg : ratedVoltage_reg; // R1
	wire [7:0] levelNext = (ampSat > refNext) ? refNext : ampSat; // R1
	// Back-EMF code is shifted right by the amplifier scale code before setting the gain.
	wire [7:0] bemfVolts = calibBackemfLevel_reg >> backemfAmpScale; // R10
	wire [7:0] baseGain = (8'hFF - bemfVolts) >> (2'h3 - loopGainSel); // R11
	wire [12:0] brakeGain = {5'h00, baseGain} * {8'h00, brakeMult(brakeGainRatio)}; // R14

	always @(posedge sys_clk) begin
		if (!rst_n) begin
			driveRef <= 8'h00;
			driveLevel <= 8'h00;
			feedbackGain <= 12'h000;
			actuatorLra <= 1'b0;
		end else begin
			driveRef <= refNext;
			driveLevel <= levelNext;
			feedbackGain <= brakeActive ? brakeGain[11:0] : {4'h0, baseGain}; // R11
			actuatorLra <= actuatorTypeSel; // R13
		end
	end

endmodule // hcf_calib_feedback

`default_nettype wire

// file: pkg/hcf_regs.vh
/*
 * Register offsets, reset values, field positions, code scale and bus address for the
 * haptic calibration and feedback register bank.
 * Assumes byte-wide registers addressed by an 8-bit pointer over the two-wire bus.
 */
`ifndef HCF_REGS_VH
`define HCF_REGS_VH

// Register offsets.
`define HCF_OFS_RATED_VOLTAGE 8'h16
`define HCF_OFS_OVERDRIVE_CLAMP 8'h17
`define HCF_OFS_CALIB_LOSS_COMP 8'h18
`define HCF_OFS_CALIB_BACKEMF 8'h19
`define HCF_OFS_FEEDBACK_CTRL 8'h1A

// Reset values.
`define HCF_RST_RATED_VOLTAGE 8'h3F
`define HCF_RST_OVERDRIVE_CLAMP 8'h89
`define HCF_RST_CALIB_LOSS_COMP 8'h0D
`define HCF_RST_CALIB_BACKEMF 8'h6D
`define HCF_RST_FEEDBACK_CTRL 8'h36

// Feedback control field positions.
`define HCF_FB_ACT_TYPE_BIT 7
`define HCF_FB_BRAKE_MSB 6
`define HCF_FB_BRAKE_LSB 4
`define HCF_FB_LOOP_MSB 3
`define HCF_FB_LOOP_LSB 2
`define HCF_FB_BEMF_MSB 1
`define HCF_FB_BEMF_LSB 0

// Fixed-point scale of the 8-bit result codes.
`define HCF_CODE_FULL_SCALE 16'h00FF

// Two-wire bus device address, arbitrary value.
`define HCF_DEV_ADDR 7'h2A

`endif

// file: tb/hcf_calib_feedback_sva.sv
/* Port assertions for the haptic calibration and feedback bank.
   Assumes binding to hcf_calib_feedback on one sys_clk domain. */
`timescale 1ns/1ps
`default_nettype none
module hcf_calib_feedback_sva (
	// Clock and reset.
	input wire logic sys_clk,
	input wire logic rst_n,
	// Calibration.
	input wire logic calStart,
	input wire logic calBusy,
	input wire logic calDone,
	// Playback.
	input wire logic brakeActive,
	input wire logic [7:0] playAmp,
	input wire logic [7:0] driveRef,
	input wire logic [7:0] driveLevel,
	input wire logic [11:0] feedbackGain
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_n);
	a_drive_capped: assert property (driveLevel <= driveRef)
		else $error("drive level above reference");
	a_gain_floor: assert property (driveLevel >= (($past(playAmp) < driveRef) ?
		$past(playAmp) : driveRef)) else $error("drive below plain amplitude");
	a_zero_amp: assert property ($past(playAmp) == 8'h00 |-> driveLevel == 8'h00)
		else $error("drive without amplitude");
	a_done_pulse: assert property (calDone |=> !calDone)
		else $error("done longer than one cycle");
	a_done_busy: assert property (calDone |-> !calBusy && $past(calBusy))
		else $error("done without busy");
	a_busy_cause: assert property ($rose(calBusy) |-> $past(calStart))
		else $error("busy without start");
	a_busy_end: assert property ($fell(calBusy) |-> calDone)
		else $error("busy ended without done");
	a_brake_boost: assert property ($past(brakeActive) && !$past(brakeActive, 2)
		|-> feedbackGain >= $past(feedbackGain)) else $error("brake lowered gain");
endmodule // hcf_calib_feedback_sva
bind hcf_calib_feedback hcf_calib_feedback_sva hcf_calib_feedback_sva_i (.sys_clk(sys_clk),
	.rst_n(rst_n), .calStart(calStart), .calBusy(calBusy), .calDone(calDone),
	.brakeActive(brakeActive), .playAmp(playAmp), .driveRef(driveRef),
	.driveLevel(driveLevel), .feedbackGain(feedbackGain));
`default_nettype wire

// file: tb/hcf_calib_feedback_tb_top.sv
/* Self-checking bench for the haptic calibration and feedback bank.
   Assumes the host model and the bound checker are compiled alongside. */
`timescale 1ns/1ps
`default_nettype none
module hcf_calib_feedback_tb_top;
	logic sys_clk = 1'h0;
	logic rst_n = 1'h0;
	logic calStart = 1'h0;
	logic measValid = 1'h0;
	logic loopClosed = 1'h0;
	logic overdriveActive = 1'h0;
	logic brakeActive = 1'h0;
	logic [7:0] measImpedance = 8'h00;
	logic [7:0] measBackemf = 8'h00;
	logic [7:0] playAmp = 8'h00;
	wire logic scl, hostPull, sdaOut, sdaOe, calBusy, calDone, actuatorLra;
	wire logic [7:0] calRatedRef, driveRef, driveLevel;
	wire logic [11:0] feedbackGain;
	wire logic sdaWire = ~(sdaOe | hostPull);
	int badCount = 0;
	int cmpCount = 0;
	int cyc = 0;
	hcf_calib_feedback hcf_calib_feedback_i (.sys_clk(sys_clk), .rst_n(rst_n), .sclIn(scl),
		.sdaIn(sdaWire), .sdaOut(sdaOut), .sdaOe(sdaOe), .calStart(calStart),
		.measValid(measValid), .measImpedance(measImpedance), .measBackemf(measBackemf),
		.calBusy(calBusy), .calDone(calDone), .calRatedRef(calRatedRef),
		.loopClosed(loopClosed), .overdriveActive(overdriveActive),
		.brakeActive(brakeActive), .playAmp(playAmp), .driveRef(driveRef),
		.driveLevel(driveLevel), .feedbackGain(feedbackGain), .actuatorLra(actuatorLra));
	hcf_host_model hcf_host_model_i (.sys_clk(sys_clk), .scl(scl), .sdaPull(hostPull),
		.sdaWire(sdaWire));
	initial forever #4 sys_clk = ~sys_clk;
	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == 90000) begin
			badCount++;
			results();
		end
	end
	////////////////////////////////////////////////////////////////////////////
	task automatic chk(input string n, input logic [11:0] e, input logic [11:0] s);
		cmpCount++;
		if (s !== e) begin
			badCount++;
			$display("[FAIL] %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask
	task automatic wr(input logic [7:0] p, input logic [7:0] d);
		int n;
		hcf_host_model_i.regWrite(p, d, n);
		chk("write ack", 12'h000, n[11:0]);
	endtask
	task automatic rd(input logic [7:0] p, input logic [7:0] e);
		int n;
		logic [7:0] d;
		hcf_host_model_i.regRead(p, d, n);
		chk("read ack", 12'h000, n[11:0]);
		chk("read data", {4'h0, e}, {4'h0, d});
	endtask
	task automatic t_reset_vals();
		logic [7:0] rv [5] = '{8'h3F, 8'h89, 8'h0D, 8'h6D, 8'h36};
		for (int i = 0; i < 5; i++) rd(8'h16 + i[7:0], rv[i]);
		chk("sda out", 12'h000, {11'h000, sdaOut});
		wr(8'h20, 8'hA5);
		rd(8'h20, 8'h00);
	endtask
	task automatic t_fb_fields();
		wr(8'h1A, 8'h80);
		tick(2);
		chk("lra", 12'h001, {11'h000, actuatorLra});
		wr(8'h1A, 8'h36);
		tick(2);
		chk("erm", 12'h000, {11'h000, actuatorLra});
		rd(8'h1A, 8'h36);
	endtask
	task automatic t_drive_ref();
		playAmp = 8'hFF;
		wr(8'h17, 8'h50);
		tick(2);
		chk("open ref", 12'h050, {4'h0, driveRef});
		chk("open level", 12'h050, {4'h0, driveLevel});
		loopClosed = 1'h1;
		tick(2);
		chk("rated ref", 12'h03F, {4'h0, driveRef});
		overdriveActive = 1'h1;
		tick(2);
		chk("od ref", 12'h050, {4'h0, driveRef});
		chk("od level", 12'h050, {4'h0, driveLevel});
		overdriveActive = 1'h0;
		brakeActive = 1'h1;
		tick(2);
		chk("brake ref", 12'h050, {4'h0, driveRef});
		brakeActive = 1'h0;
		loopClosed = 1'h0;
	endtask
	task automatic t_comp();
		playAmp = 8'h20;
		wr(8'h18, 8'h00);
		tick(2);
		chk("comp zero", 12'h020, {4'h0, driveLevel});
		wr(8'h18, 8'hFF);
		tick(2);
		chk("comp full", 12'h040, {4'h0, driveLevel});
	endtask
	task automatic t_calib(input logic [7:0] rated, input logic [7:0] imp, input logic [7:0] bemf);
		int w;
		wr(8'h16, rated);
		calStart = 1'h1;
		tick(1);
		calStart = 1'h0;
		chk("busy", 12'h001, {11'h000, calBusy});
		chk("rated latch", {4'h0, rated}, {4'h0, calRatedRef});
		measImpedance = imp;
		measValid = 1'h1;
		tick(1);
		measBackemf = bemf;
		tick(1);
		measValid = 1'h0;
		w = 0;
		while (calDone !== 1'h1 && w < 4) begin
			tick(1);
			w++;
		end
		chk("done", 12'h001, {11'h000, calDone});
		tick(1);
		chk("done pulse", 12'h000, {11'h000, calDone});
		rd(8'h18, 8'hFF - imp);
		rd(8'h19, bemf);
	endtask
	task automatic t_brake();
		logic [4:0] mult [8] = '{5'h01, 5'h02, 5'h03, 5'h04, 5'h06, 5'h08, 5'h10, 5'h10};
		wr(8'h19, 8'h55);
		loopClosed = 1'h1;
		brakeActive = 1'h1;
		for (int c = 0; c < 8; c++) begin
			wr(8'h1A, {1'h0, c[2:0], 4'hC});
			tick(2);
			chk("brake gain", 12'h0AA * mult[c], feedbackGain);
		end
		brakeActive = 1'h0;
		tick(2);
		chk("drive gain", 12'h0AA, feedbackGain);
		wr(8'h1A, 8'h09);
		tick(2);
		chk("scaled gain", 12'h06A, feedbackGain);
	endtask
	task automatic results();
		$display("comparisons %0d mismatches %0d", cmpCount, badCount);
		if (badCount == 0 && cmpCount > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	initial begin
		tick(4);
		rst_n = 1'h1;
		tick(2);
		t_reset_vals();
		t_fb_fields();
		t_drive_ref();
		t_comp();
		t_calib(8'h40, 8'h30, 8'h55);
		t_calib(8'h60, 8'h10, 8'h66);
		t_brake();
		results();
	end
endmodule // hcf_calib_feedback_tb_top
`default_nettype wire

// file: tb/hcf_host_model.sv
/* Host master model for the two-wire register bus.
   Assumes an open-drain data wire resolved by the bench with a pull-up. */
`timescale 1ns/1ps
`include "hcf_regs.vh"
`default_nettype none
module hcf_host_model (
	// Clock.
	input wire logic sys_clk,
	// Bus pins.
	output var logic scl,
	output var logic sdaPull,
	input wire logic sdaWire
);
	initial begin
		scl = 1'h1;
		sdaPull = 1'h0;
	end
	task automatic waitClk(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask
	task automatic sendBit(input logic b);
		waitClk(3);
		sdaPull = ~b;
		waitClk(8);
		scl = 1'h1;
		waitClk(10);
		scl = 1'h0;
	endtask
	task automatic getBit(output logic b);
		waitClk(3);
		sdaPull = 1'h0;
		waitClk(8);
		scl = 1'h1;
		waitClk(5);
		b = sdaWire;
		waitClk(5);
		scl = 1'h0;
	endtask
	task automatic start();
		waitClk(3);
		sdaPull = 1'h0;
		waitClk(8);
		scl = 1'h1;
		waitClk(10);
		sdaPull = 1'h1;
		waitClk(10);
		scl = 1'h0;
	endtask
	task automatic stop();
		waitClk(3);
		sdaPull = 1'h1;
		waitClk(8);
		scl = 1'h1;
		waitClk(10);
		sdaPull = 1'h0;
		waitClk(10);
	endtask
	task automatic sendByte(input logic [7:0] d, inout int nak);
		logic a;
		for (int i = 7; i >= 0; i--) sendBit(d[i]);
		getBit(a);
		nak += a;
	endtask
	task automatic regWrite(input logic [7:0] p, input logic [7:0] d, output int nak);
		nak = 0;
		start();
		sendByte({`HCF_DEV_ADDR, 1'h0}, nak);
		sendByte(p, nak);
		sendByte(d, nak);
		stop();
	endtask
	task automatic regRead(input logic [7:0] p, output logic [7:0] d, output int nak);
		nak = 0;
		start();
		sendByte({`HCF_DEV_ADDR, 1'h0}, nak);
		sendByte(p, nak);
		start();
		sendByte({`HCF_DEV_ADDR, 1'h1}, nak);
		for (int i = 7; i >= 0; i--) getBit(d[i]);
		sendBit(1'h1);
		stop();
	endtask
endmodule // hcf_host_model
`default_nettype wire
